// File: hw/timer_pair_pkg.sv
// timer_pair_pkg: constants, field layout and types for the paired 16-bit timer block
// assumes a single 10 MHz clock and a plain strobe register port
// Summary of operation
// R1 - A timer counts only while its enable bit is set.
// R2 - With stop-in-idle set the timer halts in Idle; clear, it keeps running.
// R3 - With external clock selected the gating bit does nothing and reads zero.
// R4 - With internal clock, gating makes the timer count only while gate is high.
// R5 - Prescale field divides input by 1, 2, 4, 8, 16, 32, 64 or 256.
// R6 - Only the even timer has the pairing bit; set, it joins both timers.
// R7 - In paired mode the odd timer's enable, gating, prescale and source are ignored.
// R8 - Software keeps the odd stop-in-idle clear so the pair runs in Idle.
// R9 - Software avoids register access right after clearing the enable bit.
// R10 - Unimplemented control bits ignore writes and read zero.
// R11 - Source select picks bus clock (0) or external timer clock input (1).
// R12 - All control fields reset to zero: off, ungated, 16-bit, 1:1, internal.
package timer_pair_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL_EVEN = 8'h00;
    localparam logic [7:0] ADDR_CTRL_ODD = 8'h04;
    localparam logic [7:0] ADDR_COUNT_EVEN = 8'h08;
    localparam logic [7:0] ADDR_COUNT_ODD = 8'h0C;
    // control field positions
    localparam int POS_ENABLE = 15;
    localparam int POS_STOP_IN_IDLE = 13;
    localparam int POS_GATE = 7;
    localparam int POS_PRESCALE = 4;
    localparam int POS_PAIR = 3;
    localparam int POS_CLK_SEL = 1;
    // reset values and counter maximum
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;
    // terminal prescaler counts, index is the select code
    localparam logic [7:0][7:0] PRESCALE_LIMIT = {
        8'hFF, 8'h3F, 8'h1F, 8'h0F, 8'h07, 8'h03, 8'h01, 8'h00
    };

    typedef struct packed {
        logic enable;
        logic stopInIdle;
        logic gateEnable;
        logic [2:0] prescaleSel;
        logic pairWide;
        logic clockSourceSel;
    } timer_ctrl_t;

    localparam timer_ctrl_t CTRL_RESET = '{default: 1'b0};

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic write;
        logic read;
    } reg_req_t;
endpackage : timer_pair_pkg

// File: hw/timer_pair.sv
// timer_pair: even/odd 16-bit timer pair with a control register each, optional 32-bit pairing
// assumes gate and external clock inputs are synchronous to sys_clk
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
module timer_pair (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register port
    input wire timer_pair_pkg::reg_req_t regReq,
    output logic [31:0] readData_q,
    // device and timer pins
    input wire logic idleMode,
    input wire logic gateIn,
    input wire logic extClk,
    // timer state
    output logic [15:0] countEven_q,
    output logic [15:0] countOdd_q
);
    import timer_pair_pkg::*;

    // ************************************************************
    // field decode and readback
    // ************************************************************
    function automatic timer_ctrl_t unpackCtrl(input logic [31:0] w, input logic hasPair);
        timer_ctrl_t c;
        c.enable = w[POS_ENABLE];
        c.stopInIdle = w[POS_STOP_IN_IDLE];
        c.gateEnable = w[POS_GATE];
        c.prescaleSel = w[POS_PRESCALE +: 3];
        c.pairWide = w[POS_PAIR] & hasPair; // see R6
        c.clockSourceSel = w[POS_CLK_SEL];
        return c;
    endfunction : unpackCtrl

    function automatic logic [31:0] packCtrl(input timer_ctrl_t c);
        logic [31:0] w;
        w = 32'h0000_0000; // see R10
        w[POS_ENABLE] = c.enable;
        w[POS_STOP_IN_IDLE] = c.stopInIdle;
        w[POS_GATE] = c.gateEnable & ~c.clockSourceSel; // see R3
        w[POS_PRESCALE +: 3] = c.prescaleSel;
        w[POS_PAIR] = c.pairWide;
        w[POS_CLK_SEL] = c.clockSourceSel;
        return w;
    endfunction : packCtrl

    // ************************************************************
    // control registers
    // ************************************************************
    timer_ctrl_t ctrlEven_q;
    timer_ctrl_t ctrlOdd_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlEven_q <= CTRL_RESET; // see R12
            ctrlOdd_q <= CTRL_RESET;
        end else if (regReq.write) begin
            if (regReq.addr == ADDR_CTRL_EVEN) begin
                ctrlEven_q <= unpackCtrl(regReq.wdata, 1'b1);
            end
            if (regReq.addr == ADDR_CTRL_ODD) begin
                ctrlOdd_q <= unpackCtrl(regReq.wdata, 1'b0); // see R6
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            readData_q <= 32'h0000_0000;
        end else if (regReq.read) begin
            unique case (regReq.addr)
                ADDR_CTRL_EVEN: readData_q <= packCtrl(ctrlEven_q);
                ADDR_CTRL_ODD: readData_q <= packCtrl(ctrlOdd_q);
                ADDR_COUNT_EVEN: readData_q <= {16'h0000, countEven_q};
                ADDR_COUNT_ODD: readData_q <= {16'h0000, countOdd_q};
                default: readData_q <= 32'h0000_0000;
            endcase
        end else begin
            readData_q <= 32'h0000_0000;
        end
    end

    // ************************************************************
    // effective settings and count qualification
    // ************************************************************
    logic wide;
    timer_ctrl_t eff [2];
    logic stopIdle [2];
    logic run [2];
    logic tickIn [2];
    logic presTick [2];
    logic extClkPrev_q;
    logic extEdge;

    assign wide = ctrlEven_q.pairWide;
    assign eff[0] = ctrlEven_q;
    assign eff[1] = wide ? ctrlEven_q : ctrlOdd_q; // see R7
    // pair halts in idle if either half asks; odd half must stay clear
    assign stopIdle[0] = ctrlEven_q.stopInIdle | (wide & ctrlOdd_q.stopInIdle); // see R2, R8
    assign stopIdle[1] = wide ? stopIdle[0] : ctrlOdd_q.stopInIdle; // see R2
    assign extEdge = extClk & ~extClkPrev_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            extClkPrev_q <= 1'b0;
        end else begin
            extClkPrev_q <= extClk;
        end
    end

    // ************************************************************
    // prescalers
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_timer
            logic [7:0] psCnt_q;
            logic srcPulse;
            logic gateOk;
            assign run[gi] = eff[gi].enable & ~(idleMode & stopIdle[gi]); // see R1, R2
            assign srcPulse = eff[gi].clockSourceSel ? extEdge : 1'b1; // see R11
            assign gateOk = eff[gi].clockSourceSel | ~eff[gi].gateEnable | gateIn; // see R3, R4
            assign tickIn[gi] = run[gi] & srcPulse & gateOk;
            assign presTick[gi] = tickIn[gi] &
                (psCnt_q >= PRESCALE_LIMIT[eff[gi].prescaleSel]); // see R5

            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    psCnt_q <= PRESCALE_RESET;
                end else if (!run[gi]) begin
                    psCnt_q <= PRESCALE_RESET; // see R1
                end else if (presTick[gi]) begin
                    psCnt_q <= PRESCALE_RESET; // see R5
                end else if (tickIn[gi]) begin
                    psCnt_q <= psCnt_q + 8'h01;
                end
            end
        end
    endgenerate

    // ************************************************************
    // counters
    // ************************************************************
    logic incEven;
    logic incOdd;
    assign incEven = presTick[0];
    assign incOdd = wide ? (presTick[0] & (countEven_q == COUNT_MAX)) : presTick[1]; // see R6

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            countEven_q <= COUNT_RESET;
        end else if (regReq.write && regReq.addr == ADDR_COUNT_EVEN) begin
            countEven_q <= regReq.wdata[15:0];
        end else if (incEven) begin
            countEven_q <= countEven_q + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            countOdd_q <= COUNT_RESET;
        end else if (regReq.write && regReq.addr == ADDR_COUNT_ODD) begin
            countOdd_q <= regReq.wdata[15:0];
        end else if (incOdd) begin
            countOdd_q <= countOdd_q + 16'h0001;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    logic busWrite;
    assign busWrite = regReq.write;

    AST_OFF_HOLDS: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R1
        (!ctrlEven_q.enable && !busWrite) |=> $stable(countEven_q))
        else $error("even count moved while disabled");
    AST_IDLE_HALT: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R2
        (idleMode && ctrlEven_q.stopInIdle && !busWrite) |=> $stable(countEven_q))
        else $error("even count moved in idle with stop set");
    AST_IDLE_RUN: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R2
        (idleMode && ctrlEven_q.enable && !stopIdle[0] && !ctrlEven_q.clockSourceSel
         && !ctrlEven_q.gateEnable && ctrlEven_q.prescaleSel == 3'h0 && !busWrite)
        |=> countEven_q == $past(countEven_q) + 16'h0001)
        else $error("even count halted in idle with stop clear");
    AST_GATE_READ: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R3
        (regReq.read && regReq.addr == ADDR_CTRL_EVEN && ctrlEven_q.clockSourceSel)
        |=> !readData_q[POS_GATE])
        else $error("gating bit read back set with external clock");
    AST_GATE_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R4
        (ctrlEven_q.gateEnable && !ctrlEven_q.clockSourceSel && !gateIn) |-> !tickIn[0])
        else $error("gated timer ticked with gate low");
    AST_DIV_256: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R5
        presTick[0] |-> g_timer[0].psCnt_q == PRESCALE_LIMIT[eff[0].prescaleSel])
        else $error("prescaler fired at wrong count");
    AST_ODD_NO_PAIR: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R6
        !ctrlOdd_q.pairWide)
        else $error("odd timer holds a pairing bit");
    AST_PAIR_CARRY: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R7
        (wide && !ctrlEven_q.enable && !busWrite) |=> $stable(countOdd_q))
        else $error("odd half counted while even disabled in pair");
    AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R10
        $past(regReq.read) && ($past(regReq.addr) == ADDR_CTRL_EVEN
        || $past(regReq.addr) == ADDR_CTRL_ODD) |-> (readData_q & 32'hFFFF_5F05) == 32'h0)
        else $error("unimplemented control bits read nonzero");
    AST_EXT_EDGE: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R11
        (ctrlEven_q.clockSourceSel && !extEdge) |-> !tickIn[0])
        else $error("external source ticked without clock edge");
    AST_PAIR_WRAP: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R6
        (wide && presTick[0] && countEven_q == COUNT_MAX && !busWrite)
        |=> countOdd_q == $past(countOdd_q) + 16'h0001)
        else $error("odd half missed the carry in pair mode");
    AST_INT_SOURCE: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R11
        (ctrlEven_q.enable && !ctrlEven_q.clockSourceSel && !ctrlEven_q.gateEnable
         && !(idleMode && stopIdle[0])) |-> tickIn[0])
        else $error("internal source failed to tick");
    AST_PS_CLEAR: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R1
        !run[0] |=> g_timer[0].psCnt_q == PRESCALE_RESET)
        else $error("prescaler kept its count while stopped");
    AST_GATE_HIGH: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R4
        (ctrlEven_q.enable && ctrlEven_q.gateEnable && !ctrlEven_q.clockSourceSel
         && gateIn && !(idleMode && stopIdle[0])) |-> tickIn[0])
        else $error("gated timer missed a tick with gate high");
endmodule : timer_pair

// File: verif/tb.sv
// tb: self-checking bench for timer_pair, driven over its strobe register port
// assumes timer_pair_pkg is compiled first and a free-running extClk toggle
`timescale 1ns/1ps
module tb;
    import timer_pair_pkg::*;
    // ****
    // signals
    // ****
    logic sys_clk;
    logic reset_n;
    reg_req_t regReq;
    logic [31:0] readData_q;
    logic idleMode;
    logic gateIn;
    logic extClk;
    logic [15:0] countEven_q;
    logic [15:0] countOdd_q;
    logic [31:0] rdVal;
    int errCount;
    int checked;
    localparam int DIV [8] = '{1, 2, 4, 8, 16, 32, 64, 256};

    timer_pair DUT (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .regReq(regReq),
        .readData_q(readData_q),
        .idleMode(idleMode),
        .gateIn(gateIn),
        .extClk(extClk),
        .countEven_q(countEven_q),
        .countOdd_q(countOdd_q)
    );

    // ****
    // clock, external tick, watchdog
    // ****
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // one rising edge every two cycles
    initial begin
        extClk = 1'b0;
        forever @(posedge sys_clk) extClk <= ~extClk;
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        errCount++;
        summarize();
    end

    // ****
    // tasks
    // ****
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errCount++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regReq <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge sys_clk);
        regReq <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        regReq <= '{addr: a, wdata: 32'h0, write: 1'b0, read: 1'b1};
        @(posedge sys_clk);
        regReq <= '0;
        #1 rdVal = readData_q;
        @(posedge sys_clk);
        #1 cmp(readData_q, 32'h0);
    endtask : rd

    // runs for exactly 512 enabled edges, then reads both counts
    task automatic run(input logic [7:0] ca, input logic [31:0] cv, input logic [31:0] oc,
            input logic [15:0] pre, input logic id, input logic gt,
            input logic [15:0] expE, input logic [15:0] expO);
        @(posedge sys_clk);
        idleMode <= id;
        gateIn <= gt;
        wr(ADDR_CTRL_ODD, oc);
        wr(ADDR_COUNT_EVEN, {16'h0000, pre});
        wr(ADDR_COUNT_ODD, 32'h0);
        wr(ca, cv);
        repeat (510) @(posedge sys_clk);
        wr(ca, 32'h0);
        wr(ADDR_CTRL_ODD, 32'h0);
        rd(ADDR_COUNT_EVEN);
        cmp(rdVal, {16'h0000, expE});
        rd(ADDR_COUNT_ODD);
        cmp(rdVal, {16'h0000, expO});
        cmp({16'h0000, countEven_q}, {16'h0000, expE});
        cmp({16'h0000, countOdd_q}, {16'h0000, expO});
    endtask : run

    task automatic summarize;
        $display("checks=%0d errors=%0d", checked, errCount);
        if (errCount == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    // ****
    // main sequence
    // ****
    initial begin
        errCount = 0;
        checked = 0;
        reset_n = 1'b0;
        regReq = '0;
        idleMode = 1'b0;
        gateIn = 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(ADDR_CTRL_EVEN);
        cmp(rdVal, 32'h0);
        rd(ADDR_CTRL_ODD);
        cmp(rdVal, 32'h0);
        wr(ADDR_CTRL_EVEN, 32'hFFFFFFFF);
        rd(ADDR_CTRL_EVEN);
        cmp(rdVal, 32'h0000A07A);
        wr(ADDR_CTRL_ODD, 32'hFFFFFFFF);
        rd(ADDR_CTRL_ODD);
        cmp(rdVal, 32'h0000A072);
        wr(ADDR_CTRL_EVEN, 32'h00000088);
        rd(ADDR_CTRL_EVEN);
        cmp(rdVal, 32'h00000088);
        wr(ADDR_CTRL_EVEN, 32'h0);
        rd(8'h10);
        cmp(rdVal, 32'h0);
        for (int p = 0; p < 8; p++) begin
            run(ADDR_CTRL_EVEN, 32'h8000 | (p << 4), 0, 0, 0, 0, 16'(512 / DIV[p]), 0);
        end
        run(ADDR_CTRL_EVEN, 32'h8080, 0, 0, 0, 0, 16'h0000, 0);
        run(ADDR_CTRL_EVEN, 32'h8080, 0, 0, 0, 1, 16'h0200, 0);
        run(ADDR_CTRL_EVEN, 32'h8082, 0, 0, 0, 0, 16'h0100, 0);
        run(ADDR_CTRL_EVEN, 32'hA000, 0, 0, 1, 0, 16'h0000, 0);
        run(ADDR_CTRL_EVEN, 32'hA000, 0, 0, 0, 0, 16'h0200, 0);
        run(ADDR_CTRL_EVEN, 32'h8000, 0, 0, 1, 0, 16'h0200, 0);
        run(ADDR_CTRL_EVEN, 32'h8000, 0, 16'hFFF0, 0, 0, 16'h01F0, 0);
        run(ADDR_CTRL_EVEN, 32'h8008, 32'h00F2, 16'hFFF0, 1, 0, 16'h01F0, 1);
        run(ADDR_CTRL_ODD, 32'h8000, 32'h0, 0, 0, 0, 16'h0000, 16'h0200);
        summarize();
    end
endmodule : tb
